// File: src/nvc_pkg.sv
// constants and types shared by the nonvolatile sram host controller
package nvc_pkg;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;
    localparam int SEQ_LEN = 6;
    localparam int TIMER_W = 23;
    localparam int CLK_PS = 5000;
    // slowest speed grade: read and write cycle time in ns
    localparam int ACCESS_NS = 45;
    localparam int STROBE_CYC = (ACCESS_NS * 1000 + CLK_PS - 1) / CLK_PS;
    // output disable time after a strobe rises, in ns
    localparam int BUS_RELEASE_NS = 15;
    localparam int RELEASE_CYC = (BUS_RELEASE_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int CYCLE_FINISH_WINDOW_US = 1;
    localparam int FINISH_CYC = CYCLE_FINISH_WINDOW_US * (1000000 / CLK_PS);
    localparam int REQUEST_TO_BUSY_NS = 300;
    localparam int BUSY_CYC = (REQUEST_TO_BUSY_NS * 1000) / CLK_PS;
    localparam int SAVE_DURATION_US = 12500;
    localparam int SAVE_CYC = SAVE_DURATION_US * (1000000 / CLK_PS);
    localparam int RESTORE_DURATION_US = 40;
    localparam int RESTORE_CYC = RESTORE_DURATION_US * (1000000 / CLK_PS);
    localparam int POWERUP_RESTORE_DURATION_US = 20000;
    localparam int POWERUP_CYC = POWERUP_RESTORE_DURATION_US * (1000000 / CLK_PS);
    // command table: five leading addresses, then the four final ones
    localparam int SEQ_ENTRIES = 9;
    localparam logic [3:0] IDX_SAVE = 4'h5;
    localparam logic [3:0] IDX_RESTORE = 4'h6;
    localparam logic [3:0] IDX_AUTO_OFF = 4'h7;
    localparam logic [3:0] IDX_AUTO_ON = 4'h8;
    localparam logic [15:0] SEQ_TABLE [0:SEQ_ENTRIES-1] = '{
        16'h4E38, 16'hB1C7, 16'h83E0, 16'h7C1F, 16'h703F,
        16'h8FC0, 16'h4C63, 16'h8B45, 16'h4B46
    };
    localparam logic [2:0] LAST_STEP = 3'h5;

    typedef enum logic [2:0] {
        OP_READ, OP_WRITE, OP_SAVE, OP_RESTORE, OP_AUTO_OFF, OP_AUTO_ON, OP_HW_SAVE
    } nvc_op_t;
endpackage

// File: src/nvc_seq_if.sv
// carries the command table index and address between controller and table
`timescale 1ns/100ps
interface nvc_seq_if;
    logic [3:0] idx;
    logic [15:0] addr;
    modport rom (input idx, output addr);
    modport user (output idx, input addr);
endinterface

// File: src/nvc_seq_rom.sv
// command address table with registered read data
`timescale 1ns/100ps
module nvc_seq_rom (
    input wire logic clk,          // system clock
    nvc_seq_if.rom port            // index in, address out
);
    wire in_range = (port.idx < 4'(nvc_pkg::SEQ_ENTRIES));

    // registered lookup; indices past the table read as zero
    always_ff @(posedge clk) begin
        port.addr <= in_range ? nvc_pkg::SEQ_TABLE[port.idx] : 16'h0000;
    end
endmodule

// File: src/nvc_host.sv
// host controller driving the pins of a nonvolatile-backed static ram
`timescale 1ns/100ps
module nvc_host #(
    parameter int unsigned SAVE_CYC = nvc_pkg::SAVE_CYC,        // save wait in cycles
    parameter int unsigned RESTORE_CYC = nvc_pkg::RESTORE_CYC,  // restore wait in cycles
    parameter int unsigned POWERUP_CYC = nvc_pkg::POWERUP_CYC   // power-up restore wait
) (
    input wire logic clk,                                   // 200 MHz clock
    input wire logic rst,                                   // synchronous reset, high
    input wire logic req_valid,                             // user request present
    input wire nvc_pkg::nvc_op_t req_op,                    // operation kind
    input wire logic [nvc_pkg::ADDR_W-1:0] req_addr,        // byte address
    input wire logic [nvc_pkg::DATA_W-1:0] req_wdata,       // write data
    output logic req_ready,                                 // request accepted when high
    output logic rsp_valid,                                 // one-cycle completion pulse
    output logic [nvc_pkg::DATA_W-1:0] rsp_rdata,           // read data
    output logic rsp_timeout,                               // busy line never rose
    output logic nv_busy,                                   // device busy seen on line
    output logic chip_pick_n,                               // chip pick, low active
    output logic load_strobe_n,                             // load strobe, low active
    output logic output_drive_n,                            // output drive, low active
    output logic [nvc_pkg::ADDR_W-1:0] address_lines,       // address pins
    output logic [nvc_pkg::DATA_W-1:0] data_lines_o,        // data pins, out
    output logic data_lines_oe,                             // data pins, drive enable
    input wire logic [nvc_pkg::DATA_W-1:0] data_lines_i,    // data pins, in
    output logic hard_save_busy_n_o,                        // busy line out, always low
    output logic hard_save_busy_n_oe,                       // high while pulling low
    input wire logic hard_save_busy_n_i                     // busy line level
);
    if (SAVE_CYC < 1 || SAVE_CYC >= (1 << nvc_pkg::TIMER_W)) begin : g_chk_save
        $error("SAVE_CYC does not fit the timer");
    end
    if (RESTORE_CYC < 1 || RESTORE_CYC >= (1 << nvc_pkg::TIMER_W)) begin : g_chk_rest
        $error("RESTORE_CYC does not fit the timer");
    end
    if (POWERUP_CYC < 1 || POWERUP_CYC >= (1 << nvc_pkg::TIMER_W)) begin : g_chk_pwr
        $error("POWERUP_CYC does not fit the timer");
    end

    typedef enum logic [3:0] {
        ST_POWERUP, ST_IDLE, ST_LOAD, ST_SETUP, ST_STROBE, ST_RECOVER,
        ST_PULL, ST_WAIT_HIGH, ST_NV_WAIT
    } nvc_state_t;

    localparam int TW = nvc_pkg::TIMER_W;

    nvc_state_t state_q, state_d;
    logic [TW-1:0] timer_q, timer_d;
    nvc_pkg::nvc_op_t op_q;
    logic [nvc_pkg::ADDR_W-1:0] addr_q;
    logic [nvc_pkg::DATA_W-1:0] wdata_q;
    logic [2:0] step_q;
    logic cp_n_q, ls_n_q, od_n_q, doe_q, hsb_oe_q, ready_q, rsp_q, tmo_q, busy_q;
    logic [nvc_pkg::ADDR_W-1:0] addr_pins_q;
    logic [nvc_pkg::DATA_W-1:0] rdata_q;

    nvc_seq_if seq_bus ();

    nvc_seq_rom u_rom (
        .clk(clk),
        .port(seq_bus.rom)
    );

    // decode of the request kind and of the table slot for this step
    wire is_seq = (op_q == nvc_pkg::OP_SAVE) || (op_q == nvc_pkg::OP_RESTORE) ||
                  (op_q == nvc_pkg::OP_AUTO_OFF) || (op_q == nvc_pkg::OP_AUTO_ON);
    wire is_write = (op_q == nvc_pkg::OP_WRITE);
    wire last_step = (step_q == nvc_pkg::LAST_STEP);
    wire [3:0] final_idx = (op_q == nvc_pkg::OP_SAVE) ? nvc_pkg::IDX_SAVE :
                           (op_q == nvc_pkg::OP_RESTORE) ? nvc_pkg::IDX_RESTORE :
                           (op_q == nvc_pkg::OP_AUTO_OFF) ? nvc_pkg::IDX_AUTO_OFF :
                           nvc_pkg::IDX_AUTO_ON;
    assign seq_bus.idx = last_step ? final_idx : {1'b0, step_q};
    wire timer_zero = (timer_q == '0);
    wire line_high = hard_save_busy_n_i;
    wire accept = ready_q && req_valid;
    // top bit is don't-care for the device's matcher; drive zero
    wire [nvc_pkg::ADDR_W-1:0] pin_addr = is_seq ? {1'b0, seq_bus.addr} : addr_q;

    // sequencing of one access, one command sequence or one hardware save
    always_comb begin
        state_d = state_q;
        timer_d = timer_zero ? timer_q : timer_q - 1'b1;
        unique case (state_q)
            ST_POWERUP: if (timer_zero) state_d = ST_IDLE;
            ST_IDLE: if (accept) begin
                state_d = (req_op == nvc_pkg::OP_HW_SAVE) ? ST_PULL : ST_LOAD;
                timer_d = TW'(nvc_pkg::FINISH_CYC - 1);
            end
            // a low busy line means a save is running; hold off any access
            ST_LOAD: if (line_high) state_d = ST_SETUP;
            ST_SETUP: begin
                state_d = ST_STROBE;
                timer_d = TW'(nvc_pkg::STROBE_CYC - 1);
            end
            ST_STROBE: if (timer_zero) begin
                state_d = ST_RECOVER;
                timer_d = TW'(nvc_pkg::RELEASE_CYC - 1);
            end
            ST_RECOVER: if (timer_zero) begin
                if (is_seq && !last_step) begin
                    state_d = ST_LOAD;
                end else if (op_q == nvc_pkg::OP_SAVE) begin
                    state_d = ST_NV_WAIT;
                    timer_d = TW'(SAVE_CYC - 1);
                end else if (op_q == nvc_pkg::OP_RESTORE) begin
                    state_d = ST_NV_WAIT;
                    timer_d = TW'(RESTORE_CYC - 1);
                end else begin
                    state_d = ST_IDLE;
                end
            end
            ST_PULL: if (timer_zero) begin
                state_d = ST_WAIT_HIGH;
                timer_d = TW'(SAVE_CYC - 1);
            end
            ST_NV_WAIT: if (timer_zero) begin
                state_d = ST_WAIT_HIGH;
                timer_d = TW'(SAVE_CYC - 1);
            end
            ST_WAIT_HIGH: if (line_high || timer_zero) state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    // state, timer and request capture
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_POWERUP;
            timer_q <= TW'(POWERUP_CYC - 1);
            op_q <= nvc_pkg::OP_READ;
            addr_q <= '0;
            wdata_q <= '0;
        end else begin
            state_q <= state_d;
            timer_q <= timer_d;
            if (accept) begin
                op_q <= req_op;
                addr_q <= req_addr;
                wdata_q <= req_wdata;
            end
        end
    end

    // step counter: reset at acceptance so every sequence starts at slot zero
    always_ff @(posedge clk) begin
        if (rst || accept) begin
            step_q <= 3'h0;
        end else if (state_q == ST_RECOVER && timer_zero && is_seq && !last_step) begin
            step_q <= step_q + 3'h1;
        end
    end

    // pin strobes; command reads never lower load strobe
    wire in_strobe = (state_d == ST_STROBE);
    always_ff @(posedge clk) begin
        if (rst) begin
            cp_n_q <= 1'b1;
            ls_n_q <= 1'b1;
            od_n_q <= 1'b1;
        end else begin
            cp_n_q <= !in_strobe;
            ls_n_q <= !(in_strobe && is_write);
            od_n_q <= !(in_strobe && !is_write);
        end
    end

    // address and data pins; address set at setup and held to cycle end
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_pins_q <= '0;
            doe_q <= 1'b0;
        end else begin
            // table data trail their index by a cycle, so the pins load again
            // as setup ends; a plain access simply loads the same address twice
            if (state_d == ST_SETUP || state_q == ST_SETUP) addr_pins_q <= pin_addr;
            // data held through recovery to cover the write hold time
            doe_q <= is_write && (state_d == ST_SETUP || state_d == ST_STROBE ||
                                  state_d == ST_RECOVER);
        end
    end

    // read capture, busy pull and user handshake
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= '0;
            hsb_oe_q <= 1'b0;
            ready_q <= 1'b0;
            rsp_q <= 1'b0;
            tmo_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            if (state_q == ST_STROBE && timer_zero && op_q == nvc_pkg::OP_READ) begin
                rdata_q <= data_lines_i;
            end
            hsb_oe_q <= (state_d == ST_PULL);
            ready_q <= (state_d == ST_IDLE) && !accept;
            rsp_q <= (state_q != ST_IDLE) && (state_q != ST_POWERUP) && (state_d == ST_IDLE);
            if (state_q == ST_WAIT_HIGH && state_d == ST_IDLE) tmo_q <= !line_high;
            else if (accept) tmo_q <= 1'b0;
            busy_q <= !line_high;
        end
    end

    assign req_ready = ready_q;
    assign rsp_valid = rsp_q;
    assign rsp_rdata = rdata_q;
    assign rsp_timeout = tmo_q;
    assign nv_busy = busy_q;
    assign chip_pick_n = cp_n_q;
    assign load_strobe_n = ls_n_q;
    assign output_drive_n = od_n_q;
    assign address_lines = addr_pins_q;
    assign data_lines_o = wdata_q;
    assign data_lines_oe = doe_q;
    assign hard_save_busy_n_o = 1'b0;
    assign hard_save_busy_n_oe = hsb_oe_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_read_strobes: assert property (!chip_pick_n && !output_drive_n |-> load_strobe_n)
        else $error("read with load strobe low");
    a_write_no_drive: assert property (!load_strobe_n |-> output_drive_n && data_lines_oe)
        else $error("write without data or with output drive low");
    a_addr_stable: assert property (!chip_pick_n && !$past(chip_pick_n) |->
        $stable(address_lines))
        else $error("address moved during access");
    a_strobe_width: assert property ($fell(chip_pick_n) |->
        !chip_pick_n [*8] ##1 !chip_pick_n ##1 chip_pick_n)
        else $error("strobe width not nine cycles");
    a_seq_reads_only: assert property (is_seq && !chip_pick_n |->
        load_strobe_n && !address_lines[16])
        else $error("command cycle not a plain read");
    a_seq_in_order: assert property ($rose(chip_pick_n) && is_seq && !last_step |->
        ##[1:8] !chip_pick_n && address_lines[15:0] == nvc_pkg::SEQ_TABLE[seq_bus.idx])
        else $error("command address out of order");
    a_no_access_busy: assert property (state_q == ST_NV_WAIT || state_q == ST_WAIT_HIGH ||
        state_q == ST_PULL |-> chip_pick_n)
        else $error("access during save or restore");
    a_pull_window: assert property ($rose(hard_save_busy_n_oe) |-> hard_save_busy_n_oe [*8])
        else $error("busy pull too short");
    a_start_line_high: assert property ($fell(chip_pick_n) |->
        $past(hard_save_busy_n_i, 2))
        else $error("access started with busy line low");

    c_read_done: cover property (rsp_valid && op_q == nvc_pkg::OP_READ);
    c_save_done: cover property (rsp_valid && op_q == nvc_pkg::OP_SAVE);
    c_hw_save: cover property (rsp_valid && op_q == nvc_pkg::OP_HW_SAVE && !rsp_timeout);
    c_wait_busy: cover property (state_q == ST_LOAD && !hard_save_busy_n_i);
endmodule

// File: tb/nvc_dev_model.sv
// behavioural model of the nonvolatile-backed static ram facing the host
`timescale 1ns/100ps
module nvc_dev_model (
    input wire logic clk,                   // model sampling clock
    input wire logic chip_pick_n,           // chip pick
    input wire logic load_strobe_n,         // load strobe
    input wire logic output_drive_n,        // output drive
    input wire logic [16:0] address_lines,  // address pins
    input wire logic [7:0] data_in,         // data wire level
    output logic [7:0] data_out,            // read data
    output logic data_oe,                   // high while driving data
    input wire logic hard_save_busy_n,      // busy wire level
    output logic busy_pull,                 // high while pulling busy low
    input wire logic power_low,             // supply below threshold
    output int save_cnt,                    // saves performed
    output int restore_cnt,                 // restores performed
    output logic auto_en                    // automatic save armed
);
    localparam logic [15:0] CMD [0:8] = '{16'h4E38, 16'hB1C7, 16'h83E0, 16'h7C1F,
        16'h703F, 16'h8FC0, 16'h4C63, 16'h8B45, 16'h4B46};
    logic [7:0] mem [0:131071] = '{default: 8'h00};
    logic [7:0] nv [0:131071] = '{default: 8'h00};
    logic pending = 1'h0;
    logic wr_seen = 1'h0;
    logic sel_prev = 1'h1;
    logic pwr_prev = 1'h0;
    logic [16:0] a_last = 17'h00000;
    int step = 0;
    int busy_cnt = 0;
    int hold_cnt = 0;
    int req_cnt = 0;
    logic idle;
    logic sel_n;
    logic final_hz;
    initial begin
        save_cnt = 0;
        restore_cnt = 0;
        auto_en = 1'h1;
    end
    // access qualification; the sixth read of a save or restore floats
    assign idle = busy_cnt == 0 && hold_cnt == 0 && !power_low;
    assign sel_n = chip_pick_n | (output_drive_n & load_strobe_n);
    assign final_hz = step == 5 &&
        (address_lines[15:0] == CMD[5] || address_lines[15:0] == CMD[6]);
    assign data_oe = !chip_pick_n && !output_drive_n && load_strobe_n && hard_save_busy_n
        && idle && !final_hz;
    assign data_out = mem[address_lines];
    assign busy_pull = hold_cnt != 0;
    // sequence tracking, writes and save timing
    always @(posedge clk) begin
        sel_prev <= sel_n;
        pwr_prev <= power_low;
        if (busy_cnt != 0) busy_cnt <= busy_cnt - 1;
        if (hold_cnt != 0) hold_cnt <= hold_cnt - 1;
        if (!sel_n) begin
            a_last <= address_lines;
            wr_seen <= wr_seen | !load_strobe_n;
        end
        if (!chip_pick_n && !load_strobe_n && hard_save_busy_n && idle) begin
            mem[address_lines] <= data_in;
            pending <= 1'h1;
        end
        if (sel_n && !sel_prev && idle) begin
            wr_seen <= 1'h0;
            if (wr_seen) step <= 0;
            else if (step == 5 && a_last[15:0] == CMD[5]) begin
                nv <= mem;
                pending <= 1'h0;
                save_cnt <= save_cnt + 1;
                busy_cnt <= 30;
                hold_cnt <= 30;
                step <= 0;
            end else if (step == 5 && a_last[15:0] == CMD[6]) begin
                mem <= nv;
                pending <= 1'h0;
                restore_cnt <= restore_cnt + 1;
                busy_cnt <= 10;
                step <= 0;
            end else if (step == 5 && a_last[15:0] == CMD[7]) begin
                auto_en <= 1'h0;
                step <= 0;
            end else if (step == 5 && a_last[15:0] == CMD[8]) begin
                auto_en <= 1'h1;
                step <= 0;
            end else if (a_last[15:0] == CMD[step]) step <= step + 1;
            else step <= (a_last[15:0] == CMD[0]) ? 1 : 0;
        end
        // outside pull: busy shown at 100 ns, held past the host's grace window
        if (!hard_save_busy_n && hold_cnt == 0) req_cnt <= req_cnt + 1;
        else req_cnt <= 0;
        if (req_cnt == 20 && pending) begin
            nv <= mem;
            pending <= 1'h0;
            save_cnt <= save_cnt + 1;
            hold_cnt <= 210;
        end
        if (power_low && !pwr_prev && auto_en && pending && hold_cnt == 0) begin
            nv <= mem;
            pending <= 1'h0;
            save_cnt <= save_cnt + 1;
            hold_cnt <= 30;
        end
    end
endmodule

// File: tb/tb.sv
// self-checking bench for the nonvolatile sram host controller
`timescale 1ns/100ps
module tb;
    typedef struct {nvc_pkg::nvc_op_t op; logic [7:0] data;} nvc_note_t;
    logic clk, rst, req_valid, req_ready, rsp_valid, rsp_timeout, nv_busy;
    logic chip_pick_n, load_strobe_n, output_drive_n, data_lines_oe, dev_oe, float_q;
    logic hsb_o, hsb_oe, busy_pull, power_low, auto_en;
    logic [16:0] req_addr, address_lines;
    logic [7:0] req_wdata, rsp_rdata, data_lines_o, dev_data, data_wire;
    logic hsb_wire;
    nvc_pkg::nvc_op_t req_op;
    int save_cnt, restore_cnt;
    int error_cnt = 0;
    int check_count = 0;
    nvc_note_t exp_q [$];
    // shared wires: data floats to a moving pattern, busy line has a pull-up
    assign data_wire = data_lines_oe ? data_lines_o : (dev_oe ? dev_data : {8{float_q}});
    assign hsb_wire = (hsb_oe ? hsb_o : 1'h1) & !busy_pull;
    nvc_host #(.SAVE_CYC(50), .RESTORE_CYC(20), .POWERUP_CYC(10)) nvc_host_i (.clk(clk),
        .rst(rst), .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .rsp_timeout(rsp_timeout), .nv_busy(nv_busy),
        .chip_pick_n(chip_pick_n), .load_strobe_n(load_strobe_n),
        .output_drive_n(output_drive_n), .address_lines(address_lines),
        .data_lines_o(data_lines_o), .data_lines_oe(data_lines_oe), .data_lines_i(data_wire),
        .hard_save_busy_n_o(hsb_o), .hard_save_busy_n_oe(hsb_oe), .hard_save_busy_n_i(hsb_wire));
    nvc_dev_model nvc_dev_model_i (.clk(clk), .chip_pick_n(chip_pick_n),
        .load_strobe_n(load_strobe_n), .output_drive_n(output_drive_n),
        .address_lines(address_lines), .data_in(data_wire), .data_out(dev_data),
        .data_oe(dev_oe), .hard_save_busy_n(hsb_wire), .busy_pull(busy_pull),
        .power_low(power_low), .save_cnt(save_cnt), .restore_cnt(restore_cnt), .auto_en(auto_en));
    initial begin
        clk = 1'h0;
        float_q = 1'h0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) float_q <= ~float_q;
    task automatic stop_test();
        if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk_data(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_flag(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chk_count(input string what, input int exp, input int got);
        check_count++;
        if (got != exp) begin
            error_cnt++;
            $display("wrong value %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    // one request at a time; the note is settled by the watcher below
    task automatic do_op(input nvc_pkg::nvc_op_t op, input logic [16:0] a,
        input logic [7:0] d, input logic [7:0] ex);
        int n;
        exp_q.push_back('{op, ex});
        req_valid <= 1'h1;
        req_op <= op;
        req_addr <= a;
        req_wdata <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (req_ready !== 1'h1 && n < 2000);
        if (req_ready !== 1'h1) begin
            error_cnt++;
            stop_test();
        end
        req_valid <= 1'h0;
        n = 0;
        while (exp_q.size() != 0 && n < 5000) begin
            @(posedge clk);
            n++;
        end
        if (exp_q.size() != 0) begin
            error_cnt++;
            stop_test();
        end
    endtask
    // supply dip; the busy line must show an automatic save only when armed
    task automatic power_dip(input logic exp);
        logic seen;
        seen = 1'h0;
        power_low <= 1'h1;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            if (i == 4) power_low <= 1'h0;
            if (nv_busy === 1'h1) seen = 1'h1;
        end
        chk_flag("nv_busy", exp, seen);
    endtask
    // completion watcher
    always @(posedge clk) begin
        nvc_note_t e;
        if (rsp_valid === 1'h1) begin
            if (exp_q.size() == 0) chk_flag("rsp_valid", 1'h0, rsp_valid);
            else begin
                e = exp_q.pop_front();
                if (e.op == nvc_pkg::OP_READ) chk_data("rsp_rdata", e.data, rsp_rdata);
                chk_flag("rsp_timeout", 1'h0, rsp_timeout);
            end
        end
    end
    initial begin
        int seed;
        logic [16:0] a [0:7];
        logic [7:0] d [0:7];
        seed = 76378;
        rst = 1'h1;
        req_valid = 1'h0;
        req_op = nvc_pkg::OP_READ;
        req_addr = 17'h00000;
        req_wdata = 8'h00;
        power_low = 1'h0;
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        chk_flag("auto_en", 1'h1, auto_en);
        for (int i = 0; i < 8; i++) begin
            a[i] = 17'($random(seed));
            d[i] = 8'($random(seed));
        end
        a[1] = a[0] ^ 17'h10000; // top address bit alone tells these apart
        for (int i = 0; i < 8; i++) do_op(nvc_pkg::OP_WRITE, a[i], d[i], 8'h00);
        for (int i = 0; i < 8; i++) do_op(nvc_pkg::OP_READ, a[i], 8'h00, d[i]);
        do_op(nvc_pkg::OP_WRITE, 17'h00100, 8'h5A, 8'h00);
        do_op(nvc_pkg::OP_SAVE, 17'h00000, 8'h00, 8'h00);
        chk_count("save_cnt", 1, save_cnt);
        do_op(nvc_pkg::OP_WRITE, 17'h00100, 8'hA5, 8'h00);
        do_op(nvc_pkg::OP_RESTORE, 17'h00000, 8'h00, 8'h00);
        chk_count("restore_cnt", 1, restore_cnt);
        do_op(nvc_pkg::OP_READ, 17'h00100, 8'h00, 8'h5A);
        do_op(nvc_pkg::OP_SAVE, 17'h00000, 8'h00, 8'h00);
        chk_count("save_cnt", 2, save_cnt);
        do_op(nvc_pkg::OP_HW_SAVE, 17'h00000, 8'h00, 8'h00);
        chk_count("save_cnt", 2, save_cnt);
        do_op(nvc_pkg::OP_WRITE, 17'h00200, 8'h3C, 8'h00);
        do_op(nvc_pkg::OP_HW_SAVE, 17'h00000, 8'h00, 8'h00);
        chk_count("save_cnt", 3, save_cnt);
        do_op(nvc_pkg::OP_READ, 17'h00200, 8'h00, 8'h3C);
        do_op(nvc_pkg::OP_AUTO_OFF, 17'h00000, 8'h00, 8'h00);
        chk_flag("auto_en", 1'h0, auto_en);
        do_op(nvc_pkg::OP_WRITE, 17'h00300, 8'hC3, 8'h00);
        power_dip(1'h0);
        do_op(nvc_pkg::OP_AUTO_ON, 17'h00000, 8'h00, 8'h00);
        chk_flag("auto_en", 1'h1, auto_en);
        power_dip(1'h1);
        chk_count("save_cnt", 4, save_cnt);
        do_op(nvc_pkg::OP_READ, 17'h00300, 8'h00, 8'hC3);
        stop_test();
    end
endmodule
